// ==== shared/tamc_map.svh ====
// Register offsets, command codes, field positions and timing constants.
`ifndef TAMC_MAP_SVH
`define TAMC_MAP_SVH
`define TAMC_A_CMD 4'h0
`define TAMC_A_CTRL 4'h1
`define TAMC_A_STAT 4'h2
`define TAMC_A_OPEN 4'h3
`define TAMC_A_OPEV 4'h4
`define TAMC_A_TVOLT 4'h5
`define TAMC_A_TCURR 4'h6
`define TAMC_A_OVOLT 4'h7
`define TAMC_A_OCURR 4'h8
`define TAMC_A_MVOLT 4'h9
`define TAMC_A_MCURR 4'hA
`define TAMC_A_RATE 4'hB
`define TAMC_A_TRAN 4'hC
`define TAMC_A_SAVE 4'hD
`define TAMC_A_ERR 4'hE
`define TAMC_A_LIST 4'hF
`define TAMC_C_INIT 4'h1
`define TAMC_C_ABORT 4'h2
`define TAMC_C_BUSTRG 4'h3
`define TAMC_C_RESET 4'h4
`define TAMC_C_CONTON 4'h5
`define TAMC_C_CONTOFF 4'h6
`define TAMC_C_SRCBUS 4'h7
`define TAMC_C_SRCEXT 4'h8
`define TAMC_C_MEASTRAN 4'h9
`define TAMC_WTG_BIT 5
`define TAMC_RATE_50 8'h32
`define TAMC_RATE_60 8'h3C
`define TAMC_RATE_125 8'h7D
`define TAMC_CLK_NS 50
`define TAMC_T50_US 20000
`define TAMC_T60_US 16600
`define TAMC_T125_US 10000
`define TAMC_ERR_CMD 16'hFF9C
`define TAMC_TRAN_DEPTH 8
`define TAMC_SAVE_INT 0
`define TAMC_SAVE_SER 1
`define TAMC_SAVE_LIM 2
`define TAMC_SAVE_OUTP 3
`endif

// ==== shared/tamc_pkg.sv ====
// Types shared by the trigger and measurement command block.
package tamc_pkg;
	typedef enum logic [1:0] {TAMC_IDLE, TAMC_ARMED, TAMC_DONE} tamc_arm_t;
	typedef enum logic {TAMC_SRC_BUS, TAMC_SRC_EXT} tamc_src_t;
	typedef logic [31:0] tamc_word_t;
endpackage

// ==== hw/tamc_core.sv ====
// Trigger arming, measurement rate, readback and power-up save commands.
//
// Summary of operation
// - Abort while single-armed disarms and clears the waiting flag.
// - Abort is ignored while continuous triggering is on.
// - Initiate arms one trigger; bus trigger counts only with bus source.
// - Accepted trigger loads output from triggered voltage and current setpoints.
// - After one accepted trigger with continuous off, further triggers ignored until re-armed.
// - Initiate arms once when continuous off; redundant when continuous on.
// - Continuous on with bus source holds waiting flag bit 5 high.
// - Continuous with external source: flag drops on trigger, then rises.
// - Waiting flag transitions latch into event status when enable bit set.
// - Reset command clears continuous triggering and the waiting flag.
// - Continuous query reads 1 when enabled, 0 when disabled.
// - Rate command accepts only 50, 60 or 125 hertz.
// - Sample windows are 20 ms, 16.6 ms and 10 ms respectively.
// - Transient readback gives up to eight samples of the list's type.
// - Voltage readback reports measured sense voltage, not the setting.
// - Current readback reports measured output current, not the setting.
// - Interface save stores bus address and system setup variables.
// - Serial save stores port state, baud, pacing and echo.
// - Limits save stores limits and maximum protection values.
// - Output save stores on/off state and operating mode.
// - A list with a sample and loop count not 1 reports error -100.
// - Numeric replies are raw codes; text formatting is done by firmware.
`timescale 1ns/1ns
`default_nettype none
`include "tamc_map.svh"
module tamc_core (
	input wire logic clk, // System clock, 20 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic clkEn, // Freezes all state while low.
	input wire logic [3:0] addr, // Register index.
	input wire logic [31:0] wrData, // Write data.
	input wire logic wrStb, // Write strobe.
	input wire logic rdStb, // Read strobe.
	output logic [31:0] rdData, // Read data, one cycle after the strobe.
	input wire logic extTrigPin, // External trigger pin, asynchronous.
	input wire logic [15:0] senseVolt, // Converter voltage at sense terminals.
	input wire logic [15:0] senseCurr, // Converter output current.
	output logic [15:0] outVolt, // Programmed output voltage.
	output logic [15:0] outCurr, // Programmed output current.
	output logic [3:0] saveReq, // One-cycle save request per save group.
	output logic sampleTick // One-cycle pulse at end of each sample window.
);
	import tamc_pkg::*;

	localparam int CYC50 = `TAMC_T50_US * 1000 / `TAMC_CLK_NS;
	localparam int CYC60 = `TAMC_T60_US * 1000 / `TAMC_CLK_NS;
	localparam int CYC125 = `TAMC_T125_US * 1000 / `TAMC_CLK_NS;

	tamc_arm_t arm_q;
	tamc_src_t src_q;
	logic cont_q, wtg_q, wtgOld_q, evWtg_q, enWtg_q;
	logic [15:0] tVolt_q, tCurr_q, mVolt_q, mCurr_q, err_q;
	logic [7:0] rate_q;
	logic [18:0] winCnt_q;
	logic [18:0] winLen;
	logic [2:0] tranWr_q;
	logic [3:0] tranCnt_q;
	logic [15:0] tranMem_q [0:`TAMC_TRAN_DEPTH-1];
	logic listIsCurr_q, listSample_q;
	logic [7:0] listCount_q;
	logic [2:0] tranRd_q;
	logic ext1_q, ext2_q, ext3_q;

	logic cmdWr, trigEv, extEdge, busTrig;
	assign cmdWr = clkEn && wrStb && (addr == `TAMC_A_CMD);

	// The pin is asynchronous; the first stage feeds only the second.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext1_q <= 1'b0;
			ext2_q <= 1'b0;
			ext3_q <= 1'b0;
		end else if (clkEn) begin
			ext1_q <= extTrigPin;
			ext2_q <= ext1_q;
			ext3_q <= ext2_q;
		end
	end
	assign extEdge = ext2_q && !ext3_q && (src_q == TAMC_SRC_EXT);
	assign busTrig = cmdWr && (wrData[3:0] == `TAMC_C_BUSTRG) &&
		(src_q == TAMC_SRC_BUS);
	// Only an armed system or continuous mode takes a trigger; otherwise nothing moves.
	assign trigEv = (busTrig || extEdge) &&
		(cont_q || arm_q == TAMC_ARMED);

	// Arming state and continuous mode.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arm_q <= TAMC_IDLE;
			cont_q <= 1'b0;
			src_q <= TAMC_SRC_BUS;
		end else if (cmdWr) begin
			case (wrData[3:0])
				`TAMC_C_INIT: begin
					if (!cont_q) begin
						arm_q <= TAMC_ARMED;
					end
				end
				`TAMC_C_ABORT: begin
					if (!cont_q) begin
						arm_q <= TAMC_IDLE;
					end
				end
				`TAMC_C_RESET: begin
					cont_q <= 1'b0;
					arm_q <= TAMC_IDLE;
				end
				`TAMC_C_CONTON: cont_q <= 1'b1;
				`TAMC_C_CONTOFF: begin
					cont_q <= 1'b0;
					arm_q <= TAMC_IDLE;
				end
				`TAMC_C_SRCBUS: src_q <= TAMC_SRC_BUS;
				`TAMC_C_SRCEXT: src_q <= TAMC_SRC_EXT;
				`TAMC_C_BUSTRG: begin
					if (trigEv && !cont_q) begin
						arm_q <= TAMC_DONE;
					end
				end
				default: arm_q <= arm_q;
			endcase
		end else if (clkEn && trigEv && !cont_q) begin
			arm_q <= TAMC_DONE;
		end
	end

	// Waiting-for-trigger flag.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wtg_q <= 1'b0;
		end else if (clkEn) begin
			if (cmdWr && wrData[3:0] == `TAMC_C_RESET) begin
				wtg_q <= 1'b0;
			end else if (cmdWr && wrData[3:0] == `TAMC_C_ABORT && !cont_q) begin
				wtg_q <= 1'b0;
			end else if (cont_q && src_q == TAMC_SRC_BUS) begin
				wtg_q <= 1'b1;
			end else if (cont_q && src_q == TAMC_SRC_EXT) begin
				wtg_q <= !extEdge;
			end else if (trigEv) begin
				wtg_q <= 1'b0;
			end else if (cmdWr && wrData[3:0] == `TAMC_C_INIT) begin
				wtg_q <= 1'b1;
			end else if (!cont_q && arm_q != TAMC_ARMED) begin
				wtg_q <= 1'b0;
			end
		end
	end

	// Event latch; a new transition wins over a clear in the same cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wtgOld_q <= 1'b0;
			evWtg_q <= 1'b0;
			enWtg_q <= 1'b0;
		end else if (clkEn) begin
			wtgOld_q <= wtg_q;
			if (wrStb && addr == `TAMC_A_OPEN) begin
				enWtg_q <= wrData[`TAMC_WTG_BIT];
			end
			if (enWtg_q && (wtg_q != wtgOld_q)) begin
				evWtg_q <= 1'b1;
			end else if (rdStb && addr == `TAMC_A_OPEV) begin
				evWtg_q <= 1'b0;
			end
		end
	end

	// Setpoints and the output loaded on trigger.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tVolt_q <= 16'h0000;
			tCurr_q <= 16'h0000;
			outVolt <= 16'h0000;
			outCurr <= 16'h0000;
		end else if (clkEn) begin
			if (wrStb && addr == `TAMC_A_TVOLT) tVolt_q <= wrData[15:0];
			if (wrStb && addr == `TAMC_A_TCURR) tCurr_q <= wrData[15:0];
			if (trigEv) begin
				outVolt <= tVolt_q;
				outCurr <= tCurr_q;
			end else begin
				if (wrStb && addr == `TAMC_A_OVOLT) outVolt <= wrData[15:0];
				if (wrStb && addr == `TAMC_A_OCURR) outCurr <= wrData[15:0];
			end
		end
	end

	// Measurement rate and sample window.
	always_comb begin
		case (rate_q)
			`TAMC_RATE_50: winLen = 19'(CYC50);
			`TAMC_RATE_125: winLen = 19'(CYC125);
			default: winLen = 19'(CYC60);
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rate_q <= `TAMC_RATE_60;
			winCnt_q <= 19'h00000;
			sampleTick <= 1'b0;
			mVolt_q <= 16'h0000;
			mCurr_q <= 16'h0000;
		end else if (clkEn) begin
			if (wrStb && addr == `TAMC_A_RATE &&
				(wrData[7:0] == `TAMC_RATE_50 || wrData[7:0] == `TAMC_RATE_60 ||
				wrData[7:0] == `TAMC_RATE_125) && wrData[31:8] == 24'h000000) begin
				rate_q <= wrData[7:0];
			end
			sampleTick <= 1'b0;
			if (winCnt_q >= winLen - 19'h00001) begin
				winCnt_q <= 19'h00000;
				sampleTick <= 1'b1;
				mVolt_q <= senseVolt;
				mCurr_q <= senseCurr;
			end else begin
				winCnt_q <= winCnt_q + 19'h00001;
			end
		end
	end

	// List setup, transient capture and the loop-count check.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			listIsCurr_q <= 1'b0;
			listSample_q <= 1'b0;
			listCount_q <= 8'h01;
			err_q <= 16'h0000;
			tranWr_q <= 3'h0;
			tranCnt_q <= 4'h0;
		end else if (clkEn) begin
			if (wrStb && addr == `TAMC_A_LIST) begin
				listIsCurr_q <= wrData[0];
				listSample_q <= wrData[1];
				listCount_q <= wrData[15:8];
				tranWr_q <= 3'h0;
				tranCnt_q <= 4'h0;
				if (wrData[1] && wrData[15:8] != 8'h01) begin
					err_q <= `TAMC_ERR_CMD;
				end
			end else if (rdStb && addr == `TAMC_A_ERR) begin
				err_q <= 16'h0000;
			end
			if (sampleTick && listSample_q &&
				tranCnt_q < 4'(`TAMC_TRAN_DEPTH)) begin
				tranWr_q <= tranWr_q + 3'h1;
				tranCnt_q <= tranCnt_q + 4'h1;
			end
		end
	end

	// Sample memory, one entry per captured value.
	always_ff @(posedge clk) begin
		if (clkEn && sampleTick && listSample_q &&
			tranCnt_q < 4'(`TAMC_TRAN_DEPTH)) begin
			tranMem_q[tranWr_q] <= listIsCurr_q ? mCurr_q : mVolt_q;
		end
	end

	// Transient readback walks the captured values in order.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tranRd_q <= 3'h0;
		end else if (clkEn) begin
			if (cmdWr && wrData[3:0] == `TAMC_C_MEASTRAN) begin
				tranRd_q <= 3'h0;
			end else if (rdStb && addr == `TAMC_A_TRAN) begin
				tranRd_q <= tranRd_q + 3'h1;
			end
		end
	end

	// Save requests; the non-volatile store itself lives outside.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			saveReq <= 4'h0;
		end else if (clkEn) begin
			saveReq <= 4'h0;
			if (wrStb && addr == `TAMC_A_SAVE) begin
				saveReq[`TAMC_SAVE_INT] <= wrData[`TAMC_SAVE_INT];
				saveReq[`TAMC_SAVE_SER] <= wrData[`TAMC_SAVE_SER];
				saveReq[`TAMC_SAVE_LIM] <= wrData[`TAMC_SAVE_LIM];
				saveReq[`TAMC_SAVE_OUTP] <= wrData[`TAMC_SAVE_OUTP];
			end
		end
	end

	// Read port. Replies are raw codes; text formatting is done by firmware.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData <= 32'h00000000;
		end else if (clkEn) begin
			rdData <= 32'h00000000;
			if (rdStb) begin
				if (addr == `TAMC_A_CTRL) begin
					rdData <= {31'h0, cont_q};
				end else if (addr == `TAMC_A_STAT) begin
					rdData[`TAMC_WTG_BIT] <= wtg_q;
					rdData[1:0] <= arm_q;
					rdData[2] <= src_q;
				end else if (addr == `TAMC_A_OPEN) begin
					rdData[`TAMC_WTG_BIT] <= enWtg_q;
				end else if (addr == `TAMC_A_OPEV) begin
					rdData[`TAMC_WTG_BIT] <= evWtg_q;
				end else if (addr == `TAMC_A_TVOLT) begin
					rdData[15:0] <= tVolt_q;
				end else if (addr == `TAMC_A_TCURR) begin
					rdData[15:0] <= tCurr_q;
				end else if (addr == `TAMC_A_OVOLT) begin
					rdData[15:0] <= outVolt;
				end else if (addr == `TAMC_A_OCURR) begin
					rdData[15:0] <= outCurr;
				end else if (addr == `TAMC_A_MVOLT) begin
					rdData[15:0] <= mVolt_q;
				end else if (addr == `TAMC_A_MCURR) begin
					rdData[15:0] <= mCurr_q;
				end else if (addr == `TAMC_A_RATE) begin
					rdData[7:0] <= rate_q;
				end else if (addr == `TAMC_A_TRAN) begin
					if ({1'b0, tranRd_q} < tranCnt_q) begin
						rdData <= {1'b1, listIsCurr_q, 14'h0,
							tranMem_q[tranRd_q]};
					end
				end else if (addr == `TAMC_A_ERR) begin
					rdData[15:0] <= err_q;
				end else if (addr == `TAMC_A_LIST) begin
					rdData <= {16'h0, listCount_q, 6'h0,
						listSample_q, listIsCurr_q};
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== bench/tamc_core_chk.sv ====
// Port checker for the trigger and measurement command block.
`timescale 1ns/1ns
`default_nettype none
`include "tamc_map.svh"
module tamc_core_chk (
	input wire logic clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic clkEn, // Run enable.
	input wire logic [3:0] addr, // Index.
	input wire logic [31:0] wrData, // Write data.
	input wire logic wrStb, // Write strobe.
	input wire logic rdStb, // Read strobe.
	input wire logic [31:0] rdData, // Read data.
	input wire logic extTrigPin, // Trigger pin.
	input wire logic [15:0] outVolt, // Output voltage.
	input wire logic [3:0] saveReq // Save pulses.
);
	logic contQ, srcBusQ;
	logic [4:0] pinQ;
	logic [15:0] tvQ;
	wire cmdW = clkEn && wrStb && addr == `TAMC_A_CMD;
	wire [3:0] code = wrData[3:0];
	wire rdE = clkEn && rdStb && addr == `TAMC_A_ERR;
	wire outW = clkEn && wrStb && addr inside {`TAMC_A_CMD, `TAMC_A_OVOLT};
	// The source counts as bus only once set so, never by guessing a default.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			srcBusQ <= 1'b0;
		else if (cmdW && code == `TAMC_C_SRCBUS)
			srcBusQ <= 1'b1;
		else if (cmdW && code inside {`TAMC_C_SRCEXT, `TAMC_C_RESET})
			srcBusQ <= 1'b0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			contQ <= 1'b0;
		else if (cmdW && code == `TAMC_C_CONTON)
			contQ <= 1'b1;
		else if (cmdW && code inside {`TAMC_C_CONTOFF, `TAMC_C_RESET})
			contQ <= 1'b0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinQ <= 5'h00;
			tvQ <= 16'h0000;
		end else begin
			pinQ <= {pinQ[3:0], extTrigPin};
			if (clkEn && wrStb && addr == `TAMC_A_TVOLT)
				tvQ <= wrData[15:0];
		end
	end
	a_rd_idle: assert property (@(posedge clk) disable iff (rst)
		clkEn && !rdStb |=> rdData == 32'h0)
		else $error("read data not idle");
	a_cont_read: assert property (@(posedge clk) disable iff (rst)
		clkEn && rdStb && addr == `TAMC_A_CTRL |=> rdData == {31'h0, $past(contQ)})
		else $error("continuous query wrong");
	a_wtg_hold: assert property (@(posedge clk) disable iff (rst)
		clkEn && rdStb && addr == `TAMC_A_STAT && contQ && srcBusQ
		|=> rdData[`TAMC_WTG_BIT]) else $error("waiting flag not held");
	a_save_pulse: assert property (@(posedge clk) disable iff (rst)
		clkEn && wrStb && addr == `TAMC_A_SAVE |=> saveReq == $past(wrData[3:0]))
		else $error("save request wrong");
	a_save_quiet: assert property (@(posedge clk) disable iff (rst)
		clkEn && !(wrStb && addr == `TAMC_A_SAVE) |=> saveReq == 4'h0)
		else $error("save request without command");
	a_volt_cause: assert property (@(posedge clk) disable iff (rst)
		!$stable(outVolt) |-> $past(outW) || |pinQ)
		else $error("output voltage changed without cause");
	a_trig_load: assert property (@(posedge clk) disable iff (rst)
		cmdW && code == `TAMC_C_BUSTRG |=> $stable(outVolt) || outVolt == $past(tvQ))
		else $error("trigger loaded wrong voltage");
	a_err_clear: assert property (@(posedge clk) disable iff (rst)
		rdE ##1 !wrStb ##1 rdE |=> rdData == 32'h0)
		else $error("error not cleared by read");
endmodule
bind tamc_core tamc_core_chk chk_u (.clk(clk), .rst(rst), .clkEn(clkEn),
	.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
	.rdData(rdData), .extTrigPin(extTrigPin), .outVolt(outVolt),
	.saveReq(saveReq));
`default_nettype wire

// ==== bench/tamc_host_model.sv ====
// Host model issuing register accesses to the command block.
`timescale 1ns/1ns
`default_nettype none
`include "tamc_map.svh"
module tamc_host_model (
	input wire logic clk, // Clock.
	output logic [3:0] addr, // Index.
	output logic [31:0] wrData, // Write data.
	output logic wrStb, // Write strobe.
	output logic rdStb, // Read strobe.
	input wire logic [31:0] rdData // Read data.
);
	initial begin
		addr = 4'h0;
		wrData = 32'h0;
		wrStb = 1'b0;
		rdStb = 1'b0;
	end
	// Released lines show the inverse, so stale values never look valid.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
		addr <= ~a;
		wrData <= ~d;
		@(posedge clk);
	endtask
	// Read data stand only in the cycle after the strobe, so they are
	// taken mid-cycle, clear of the edge that replaces them.
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		addr <= ~a;
		@(negedge clk);
		d = rdData;
		@(posedge clk);
	endtask
	task automatic bus_trig();
		wr(`TAMC_A_CMD, {28'h0, `TAMC_C_SRCBUS});
		wr(`TAMC_A_CMD, {28'h0, `TAMC_C_BUSTRG});
	endtask
	task automatic set_list(input logic [7:0] loops);
		wr(`TAMC_A_LIST, {16'h0, loops, 8'h03});
	endtask
endmodule
`default_nettype wire

// ==== bench/tamc_core_tb.sv ====
// Self-checking bench for the trigger and measurement command block.
`timescale 1ns/1ns
`default_nettype none
`include "tamc_map.svh"
module tamc_core_tb;
	logic clk, rst, clkEn, extTrigPin, sampleTick, wrStb, rdStb;
	logic [3:0] addr, saveReq;
	logic [31:0] wrData, rdData, v, u;
	logic [15:0] senseVolt, senseCurr, outVolt, outCurr, saveLog;
	logic tickSeen;
	int failures, num_checks;
	tamc_core dut_u (.clk(clk), .rst(rst), .clkEn(clkEn), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.extTrigPin(extTrigPin), .senseVolt(senseVolt),
		.senseCurr(senseCurr), .outVolt(outVolt), .outCurr(outCurr),
		.saveReq(saveReq), .sampleTick(sampleTick));
	tamc_host_model host_u (.clk(clk), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			saveLog <= 16'h0000;
			tickSeen <= 1'b0;
		end else begin
			if (saveReq != 4'h0)
				saveLog <= {saveLog[11:0], saveReq};
			if (sampleTick)
				tickSeen <= 1'b1;
		end
	end
	task automatic chk(input string n, input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic w(input logic [3:0] a, input logic [31:0] d);
		host_u.wr(a, d);
	endtask
	task automatic r(input logic [3:0] a);
		host_u.rd(a, v);
	endtask
	task automatic cmd(input logic [3:0] c);
		host_u.wr(`TAMC_A_CMD, {28'h0, c});
	endtask
	task automatic t_rate();
		logic [15:0] tab [4] = '{16'h7D7D, 16'h407D, 16'h3232, 16'h3C3C};
		r(`TAMC_A_RATE);
		chk("rate reset", v, 32'h3C);
		foreach (tab[i]) begin
			w(`TAMC_A_RATE, {24'h0, tab[i][15:8]});
			r(`TAMC_A_RATE);
			chk("rate", v, {24'h0, tab[i][7:0]});
		end
		clkEn <= 1'b0;
		w(`TAMC_A_RATE, 32'h32);
		clkEn <= 1'b1;
		r(`TAMC_A_RATE);
		chk("frozen rate", v, 32'h3C);
		$display("rate test done");
	endtask
	task automatic t_single();
		w(`TAMC_A_TVOLT, 32'h1234);
		w(`TAMC_A_TCURR, 32'h0567);
		cmd(`TAMC_C_SRCEXT);
		cmd(`TAMC_C_INIT);
		cmd(`TAMC_C_BUSTRG);
		chk("ext source", {outCurr, outVolt}, 32'h0);
		host_u.bus_trig();
		chk("trig load", {outCurr, outVolt}, 32'h05671234);
		w(`TAMC_A_TVOLT, 32'h2222);
		cmd(`TAMC_C_BUSTRG);
		chk("one shot", outVolt, 32'h1234);
		cmd(`TAMC_C_INIT);
		r(`TAMC_A_STAT);
		chk("armed flag", v[`TAMC_WTG_BIT], 32'h1);
		cmd(`TAMC_C_ABORT);
		r(`TAMC_A_STAT);
		chk("abort flag", v[`TAMC_WTG_BIT], 32'h0);
		cmd(`TAMC_C_BUSTRG);
		chk("disarmed", outVolt, 32'h1234);
		cmd(`TAMC_C_INIT);
		cmd(`TAMC_C_BUSTRG);
		chk("rearmed", outVolt, 32'h2222);
		$display("single test done");
	endtask
	task automatic t_cont();
		cmd(`TAMC_C_CONTON);
		cmd(`TAMC_C_SRCBUS);
		r(`TAMC_A_CTRL);
		chk("cont on", v, 32'h1);
		r(`TAMC_A_STAT);
		u = v;
		cmd(`TAMC_C_ABORT);
		r(`TAMC_A_STAT);
		chk("abort ignored", v[5:0], u[5:0]);
		chk("flag held", v[`TAMC_WTG_BIT], 32'h1);
		cmd(`TAMC_C_RESET);
		r(`TAMC_A_CTRL);
		chk("cont reset", v, 32'h0);
		r(`TAMC_A_STAT);
		chk("flag reset", v[`TAMC_WTG_BIT], 32'h0);
		$display("continuous test done");
	endtask
	task automatic t_ext();
		w(`TAMC_A_OPEN, 32'h20);
		cmd(`TAMC_C_CONTON);
		cmd(`TAMC_C_SRCEXT);
		w(`TAMC_A_TVOLT, 32'h3333);
		r(`TAMC_A_OPEV);
		extTrigPin <= 1'b1;
		for (int n = 0; n < 20 && outVolt !== 16'h3333; n++)
			@(posedge clk);
		extTrigPin <= 1'b0;
		chk("ext trigger", outVolt, 32'h3333);
		if (outVolt !== 16'h3333)
			final_report();
		r(`TAMC_A_OPEV);
		chk("flag event", v[`TAMC_WTG_BIT], 32'h1);
		r(`TAMC_A_STAT);
		chk("flag back", v[`TAMC_WTG_BIT], 32'h1);
		$display("external test done");
	endtask
	task automatic t_save();
		for (int i = 0; i < 4; i++)
			w(`TAMC_A_SAVE, 32'h1 << i);
		@(negedge clk);
		chk("save order", saveLog, 32'h1248);
		$display("save test done");
	endtask
	task automatic t_list();
		w(`TAMC_A_LIST, 32'h0202);
		r(`TAMC_A_ERR);
		chk("list error", v, {16'h0, `TAMC_ERR_CMD});
		r(`TAMC_A_ERR);
		chk("error cleared", v, 32'h0);
		host_u.set_list(8'h01);
		r(`TAMC_A_ERR);
		chk("list ok", v, 32'h0);
		cmd(`TAMC_C_MEASTRAN);
		r(`TAMC_A_TRAN);
		chk("no sample", v[31], 32'h0);
		chk("no early tick", tickSeen, 32'h0);
		$display("list test done");
	endtask
	initial begin
		rst = 1'b1;
		clkEn = 1'b1;
		extTrigPin = 1'b0;
		senseVolt = 16'h1A2B;
		senseCurr = 16'h0C3D;
		failures = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_rate();
		t_single();
		t_cont();
		t_ext();
		t_save();
		t_list();
		final_report();
	end
endmodule
`default_nettype wire
